// File: pkg/apt_pkg.sv
// Shared constants and types of the analog pair trigger control block.
// Assumes a 32-bit classic Wishbone register bus and one module clock.
package apt_pkg;

  localparam int APT_NPAIR   = 3;
  localparam int PAIR_IDX_W  = 2;
  localparam int PAIR_BYTE_W = 8;
  localparam int SRC_W       = 5;
  localparam int ADR_W       = 8;
  localparam int DAT_W       = 32;
  localparam int SEL_W       = 4;
  localparam int NUM_PRI     = 8;
  localparam int NUM_SEC     = 9;
  localparam int NUM_CL      = 8;

  // Start-of-conversion source codes
  localparam logic [SRC_W-1:0] SRC_NONE        = 5'h00;
  localparam logic [SRC_W-1:0] SRC_SW_OWN      = 5'h01;
  localparam logic [SRC_W-1:0] SRC_SW_GLOBAL   = 5'h02;
  localparam logic [SRC_W-1:0] SRC_PWM_SPECIAL = 5'h03;
  localparam logic [SRC_W-1:0] SRC_PRI_FIRST   = 5'h04;
  localparam logic [SRC_W-1:0] SRC_PRI_LAST    = 5'h0B;
  localparam logic [SRC_W-1:0] SRC_TMR1        = 5'h0C;
  localparam logic [SRC_W-1:0] SRC_RESERVED    = 5'h0D;
  localparam logic [SRC_W-1:0] SRC_SEC_FIRST   = 5'h0E;
  localparam logic [SRC_W-1:0] SRC_SEC_LAST    = 5'h16;
  localparam logic [SRC_W-1:0] SRC_CL_FIRST    = 5'h17;
  localparam logic [SRC_W-1:0] SRC_CL_LAST     = 5'h1E;
  localparam logic [SRC_W-1:0] SRC_TMR2        = 5'h1F;

  // Register byte addresses
  localparam logic [ADR_W-1:0] OFS_PAIR_CTRL_10_11 = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PAIR_CTRL_12    = 8'h04;
  localparam logic [ADR_W-1:0] OFS_IRQ_STATUS      = 8'h08;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK        = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_GLOBAL_CTRL     = 8'h10;
  localparam int               GLOBAL_TRIG_BIT     = 0;

  // Placement of each pair's control byte: word address and byte lane
  localparam logic [ADR_W-1:0] PAIR_OFS  [APT_NPAIR] = '{8'h00, 8'h00, 8'h04};
  localparam int               PAIR_LANE [APT_NPAIR] = '{0, 1, 0};

  // One pair control byte, top bit first
  typedef struct packed {
    logic             irqEn;
    logic             pending;
    logic             swStart;
    logic [SRC_W-1:0] src;
  } apt_pair_t;

  localparam apt_pair_t APT_PAIR_RST = 8'h00;

  typedef struct packed {
    logic               pwmSpecial;
    logic [NUM_PRI-1:0] pwmPrimary;
    logic [NUM_SEC-1:0] pwmSecondary;
    logic [NUM_CL-1:0]  pwmCurLimit;
    logic               tmr1Match;
    logic               tmr2Match;
  } apt_trig_t;

  typedef struct packed {
    logic                  start;
    logic [PAIR_IDX_W-1:0] pair;
  } apt_conv_req_t;

  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } apt_arb_state_t;

endpackage

// File: rtl/apt_src_sel.sv
// Start source selector for one analog input pair.
// Assumes trigger inputs are one-cycle pulses in the module clock domain.
`timescale 1ns/1ps
module apt_src_sel
  import apt_pkg::*;
(
  input  wire logic [SRC_W-1:0] srcCode,
  input  apt_trig_t             trig,
  input  wire logic             swStart,
  input  wire logic             globalTrig,
  output logic                  fire
);

  logic [SRC_W-1:0] priOfs;
  logic [SRC_W-1:0] secOfs;
  logic [SRC_W-1:0] clOfs;

  assign priOfs = srcCode - SRC_PRI_FIRST;
  assign secOfs = srcCode - SRC_SEC_FIRST;
  assign clOfs  = srcCode - SRC_CL_FIRST;

  always_comb begin
    fire = 1'b0;
    if (srcCode == SRC_SW_OWN) begin
      fire = swStart;
    end else if (srcCode == SRC_SW_GLOBAL) begin
      fire = globalTrig;
    end else if (srcCode == SRC_PWM_SPECIAL) begin
      fire = trig.pwmSpecial;
    end else if (srcCode >= SRC_PRI_FIRST && srcCode <= SRC_PRI_LAST) begin
      fire = trig.pwmPrimary[priOfs[2:0]];
    end else if (srcCode == SRC_TMR1) begin
      fire = trig.tmr1Match;
    end else if (srcCode >= SRC_SEC_FIRST && srcCode <= SRC_SEC_LAST) begin
      fire = trig.pwmSecondary[secOfs[3:0]];
    end else if (srcCode >= SRC_CL_FIRST && srcCode <= SRC_CL_LAST) begin
      fire = trig.pwmCurLimit[clOfs[2:0]];
    end else if (srcCode == SRC_TMR2) begin
      fire = trig.tmr2Match;
    end
    // No source and the reserved code fall through and start nothing
  end

endmodule // apt_src_sel

// File: rtl/apt_conv_arb.sv
// Converter sequencer: serves pending pairs one at a time, lowest index first.
// Assumes the converter answers each start with exactly one convDone pulse.
`timescale 1ns/1ps
module apt_conv_arb
  import apt_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic [APT_NPAIR-1:0] pending,
  input  wire logic                 convDone,
  output apt_conv_req_t             convReq,
  output logic      [APT_NPAIR-1:0] doneVec
);

  apt_arb_state_t        state_r;
  logic [PAIR_IDX_W-1:0] curPair_r;
  logic                  start_r;
  logic [PAIR_IDX_W-1:0] pickPair;

  always_comb begin
    pickPair = '0;
    for (int i = APT_NPAIR - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pickPair = PAIR_IDX_W'(i);
      end
    end
  end

  // Requests wait here while the converter is busy; nothing is dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r   <= ARB_IDLE;
      curPair_r <= '0;
      start_r   <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        ARB_IDLE: begin
          if (|pending) begin
            curPair_r <= pickPair;
            start_r   <= 1'b1;
            state_r   <= ARB_BUSY;
          end
        end
        ARB_BUSY: begin
          if (convDone) begin
            state_r <= ARB_IDLE;
          end
        end
        default: state_r <= ARB_IDLE;
      endcase
    end
  end

  // Combinational so the pending bit drops at the same edge the sequencer frees up
  always_comb begin
    doneVec = '0;
    if (state_r == ARB_BUSY && convDone) begin
      doneVec[curPair_r] = 1'b1;
    end
  end

  assign convReq.start = start_r;
  assign convReq.pair  = curPair_r;

  property p_wait_served;
    @(posedge ref_clk) disable iff (!rstn)
      (state_r == ARB_IDLE && |pending) |=> (start_r && state_r == ARB_BUSY);
  endproperty
  a_wait_served: assert property (p_wait_served)
    else $error("pending pair not started by an idle converter");

endmodule // apt_conv_arb

// File: rtl/apt_pair_trigger.sv
// Trigger control for analog input pairs 10 to 12 with a Wishbone register port.
// Assumes trigger pulses are synchronous to ref_clk and the converter returns
// one convDone pulse per convReq.start.
//
// Summary of operation
// - Source code zero never starts a conversion of its pair.
// - Code one uses the pair's own software bit; code two the global one.
// - Code three starts on the PWM special event trigger.
// - Codes four to eleven pick PWM primary triggers one to eight.
// - Code twelve is timer one, code 31 timer two; thirteen starts nothing.
// - Codes fourteen to 22 pick PWM secondary triggers one to nine.
// - Codes 23 to 30 pick PWM current-limit triggers one to eight.
// - Pending sets when the selected trigger fires, clears at conversion done.
// - Done raises an interrupt request only when the pair's enable is set.
// - Software start bit requests conversion; hardware clears it once the bit itself sets pending.
// - A trigger for another pair during busy conversion is held and served once free.
// - Pair 10 in bits 4-0, pair 11 in bits 12-8, pair 12 alone.
// - Upper three bytes of the pair 12 register read zero, ignore writes.
// - Byte layout: enable, pending, start bit, then five source bits.
`timescale 1ns/1ps
module apt_pair_trigger
  import apt_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [SEL_W-1:0] sel_i,
  input  wire logic [DAT_W-1:0] dat_i,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  ack_o,
  input  apt_trig_t             trig,
  output apt_conv_req_t         convReq,
  input  wire logic             convDone,
  output logic                  irq
);

  logic                 ack_r;
  logic [DAT_W-1:0]     datOut_r;
  logic [DAT_W-1:0]     rdData;
  logic                 wrEn;
  logic                 globalTrig;
  apt_pair_t            pairCfg_r [APT_NPAIR];
  logic [APT_NPAIR-1:0] pendVec;
  logic [APT_NPAIR-1:0] fire;
  logic [APT_NPAIR-1:0] doneVec;
  logic [APT_NPAIR-1:0] wrPair;
  logic [APT_NPAIR-1:0] srcIsNone;
  logic [APT_NPAIR-1:0] srcIsRsvd;
  logic [APT_NPAIR-1:0] irqStatus_r;
  logic [APT_NPAIR-1:0] irqMask_r;
  logic [APT_NPAIR-1:0] irqEvent;
  logic [APT_NPAIR-1:0] irqClear;
  logic [SRC_W-1:0]     src11;

  // ---------------- Wishbone slave ----------------
  // One wait state: ack follows the request by one cycle and is dropped after one
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end

  // Writes take effect at the edge where the master samples ack
  assign wrEn  = cyc_i & stb_i & we_i & ack_r;
  assign ack_o = ack_r;

  always_comb begin
    rdData = '0;
    case (adr_i)
      OFS_PAIR_CTRL_10_11: rdData = {16'h0000, pairCfg_r[1], pairCfg_r[0]};
      OFS_PAIR_CTRL_12:    rdData = {24'h000000, pairCfg_r[2]};
      OFS_IRQ_STATUS:      rdData = {29'h0, irqStatus_r};
      OFS_IRQ_MASK:        rdData = {29'h0, irqMask_r};
      default:             rdData = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      datOut_r <= '0;
    end else if (cyc_i && stb_i && !ack_r) begin
      datOut_r <= rdData;
    end
  end

  assign dat_o = datOut_r;

  // Write-one pulse; the control word itself always reads zero
  assign globalTrig = wrEn && (adr_i == OFS_GLOBAL_CTRL) && sel_i[0]
                      && dat_i[GLOBAL_TRIG_BIT];

  // ---------------- Per-pair control ----------------
  genvar p;
  generate
    for (p = 0; p < APT_NPAIR; p++) begin : g_pair
      apt_pair_t wrByte;

      assign wrPair[p]    = wrEn && (adr_i == PAIR_OFS[p]) && sel_i[PAIR_LANE[p]];
      assign wrByte       = dat_i[PAIR_LANE[p]*PAIR_BYTE_W +: PAIR_BYTE_W];
      assign pendVec[p]   = pairCfg_r[p].pending;
      assign srcIsNone[p] = (pairCfg_r[p].src == SRC_NONE);
      assign srcIsRsvd[p] = (pairCfg_r[p].src == SRC_RESERVED);

      apt_src_sel u_src_sel (
        .srcCode    (pairCfg_r[p].src),
        .trig       (trig),
        .swStart    (pairCfg_r[p].swStart),
        .globalTrig (globalTrig),
        .fire       (fire[p])
      );

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          pairCfg_r[p] <= APT_PAIR_RST;
        end else begin
          if (wrPair[p]) begin
            pairCfg_r[p].src   <= wrByte.src;
            pairCfg_r[p].irqEn <= wrByte.irqEn;
          end
          // A trigger in the done cycle wins and queues a new conversion
          pairCfg_r[p].pending <= fire[p] | (pairCfg_r[p].pending & ~doneVec[p]);
          // The start bit only fires with the own-software source selected
          pairCfg_r[p].swStart <= (wrPair[p] & wrByte.swStart)
                                 | (pairCfg_r[p].swStart
                                    & ~(fire[p] & (pairCfg_r[p].src == SRC_SW_OWN)));
        end
      end

      assign irqEvent[p] = doneVec[p] & pairCfg_r[p].irqEn;
    end
  endgenerate

  apt_conv_arb u_conv_arb (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .pending  (pendVec),
    .convDone (convDone),
    .convReq  (convReq),
    .doneVec  (doneVec)
  );

  // ---------------- Interrupt ----------------
  assign irqClear = (wrEn && adr_i == OFS_IRQ_STATUS && sel_i[0])
                    ? dat_i[APT_NPAIR-1:0] : '0;

  // A completion in the same cycle as its clear stays set
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irqStatus_r <= '0;
    end else begin
      irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvent;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irqMask_r <= '0;
    end else if (wrEn && adr_i == OFS_IRQ_MASK && sel_i[0]) begin
      irqMask_r <= dat_i[APT_NPAIR-1:0];
    end
  end

  assign irq = |(irqStatus_r & irqMask_r);

  // ---------------- Checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  assign src11 = pairCfg_r[1].src;

  sequence s_sw_armed0;
    pairCfg_r[0].src == SRC_SW_OWN && pairCfg_r[0].swStart;
  endsequence

  sequence s_own_sw_fire0;
    fire[0] && pairCfg_r[0].src == SRC_SW_OWN && !wrPair[0];
  endsequence

  sequence s_done_quiet0;
    doneVec[0] && !fire[0];
  endsequence

  property p_none_idle;
    !(|(fire & srcIsNone));
  endproperty
  a_none_idle: assert property (p_none_idle)
    else $error("pair with no source fired");

  property p_sw_own;
    s_sw_armed0 |-> fire[0] ##1 pairCfg_r[0].pending;
  endproperty
  a_sw_own: assert property (p_sw_own)
    else $error("own software start did not set pending");

  property p_global_sw;
    (globalTrig && pairCfg_r[1].src == SRC_SW_GLOBAL) |=> pairCfg_r[1].pending;
  endproperty
  a_global_sw: assert property (p_global_sw)
    else $error("global software trigger ignored");

  property p_special;
    (pairCfg_r[2].src == SRC_PWM_SPECIAL && trig.pwmSpecial) |-> fire[2];
  endproperty
  a_special: assert property (p_special)
    else $error("special event trigger ignored");

  property p_primary_last;
    (pairCfg_r[2].src == SRC_PRI_LAST && trig.pwmPrimary[NUM_PRI-1]) |-> fire[2];
  endproperty
  a_primary_last: assert property (p_primary_last)
    else $error("last primary trigger not mapped");

  property p_reserved_idle;
    !(|(fire & srcIsRsvd));
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("reserved source fired");

  property p_timer2;
    (pairCfg_r[2].src == SRC_TMR2 && trig.tmr2Match) |-> fire[2];
  endproperty
  a_timer2: assert property (p_timer2)
    else $error("timer two match ignored");

  property p_secondary_last;
    (pairCfg_r[2].src == SRC_SEC_LAST && trig.pwmSecondary[NUM_SEC-1]) |-> fire[2];
  endproperty
  a_secondary_last: assert property (p_secondary_last)
    else $error("last secondary trigger not mapped");

  property p_curlimit_first;
    (pairCfg_r[2].src == SRC_CL_FIRST && trig.pwmCurLimit[0]) |-> fire[2];
  endproperty
  a_curlimit_first: assert property (p_curlimit_first)
    else $error("first current-limit trigger not mapped");

  property p_done_clears;
    s_done_quiet0 |=> !pairCfg_r[0].pending;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("pending not cleared at conversion done");

  property p_irq_done;
    (doneVec[2] && pairCfg_r[2].irqEn && irqMask_r[2]) |=> (irqStatus_r[2] && irq);
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("enabled completion raised no interrupt");

  property p_irq_off;
    (doneVec[1] && !pairCfg_r[1].irqEn && !irqStatus_r[1]) |=> !irqStatus_r[1];
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("disabled completion set interrupt status");

  property p_sw_autoclear;
    s_own_sw_fire0 |=> (!pairCfg_r[0].swStart && pairCfg_r[0].pending);
  endproperty
  a_sw_autoclear: assert property (p_sw_autoclear)
    else $error("software start bit not cleared by hardware");

  property p_field_map;
    (ack_o && !we_i && adr_i == OFS_PAIR_CTRL_10_11 && $past(cyc_i) && !$past(ack_o))
      |-> dat_o[PAIR_BYTE_W +: SRC_W] == $past(src11);
  endproperty
  a_field_map: assert property (p_field_map)
    else $error("pair eleven source not at upper byte");

  property p_upper_zero;
    (ack_o && adr_i == OFS_PAIR_CTRL_12) |-> (dat_o[DAT_W-1:PAIR_BYTE_W] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper byte of pair twelve register not zero");

  property p_reset_zero;
    @(posedge ref_clk) disable iff (1'b0)
      !rstn |=> (pairCfg_r[0] == APT_PAIR_RST && pairCfg_r[2] == APT_PAIR_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("pair control not cleared by reset");

  property p_ack_single;
    ack_o |=> !ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack held longer than one cycle");

  property p_tmr1;
    (pairCfg_r[2].src == SRC_TMR1 && trig.tmr1Match) |-> fire[2];
  endproperty
  a_tmr1: assert property (p_tmr1)
    else $error("timer one match ignored");

  property p_primary_first;
    (pairCfg_r[2].src == SRC_PRI_FIRST && trig.pwmPrimary[0]) |-> fire[2];
  endproperty
  a_primary_first: assert property (p_primary_first)
    else $error("first primary trigger not mapped");

  property p_secondary_first;
    (pairCfg_r[2].src == SRC_SEC_FIRST && trig.pwmSecondary[0]) |-> fire[2];
  endproperty
  a_secondary_first: assert property (p_secondary_first)
    else $error("first secondary trigger not mapped");

  property p_curlimit_last;
    (pairCfg_r[2].src == SRC_CL_LAST && trig.pwmCurLimit[NUM_CL-1]) |-> fire[2];
  endproperty
  a_curlimit_last: assert property (p_curlimit_last)
    else $error("last current-limit trigger not mapped");

  property p_pend_only_fire;
    (!pairCfg_r[1].pending && !fire[1]) |=> !pairCfg_r[1].pending;
  endproperty
  a_pend_only_fire: assert property (p_pend_only_fire)
    else $error("pending set without its selected trigger");

  property p_pend_drop;
    $fell(pairCfg_r[0].pending) |-> $past(doneVec[0]);
  endproperty
  a_pend_drop: assert property (p_pend_drop)
    else $error("pending cleared before conversion done");

  property p_pend_kept;
    (pairCfg_r[2].pending && !doneVec[2]) |=> pairCfg_r[2].pending;
  endproperty
  a_pend_kept: assert property (p_pend_kept)
    else $error("waiting request lost");

  property p_status_clear;
    (irqClear[2] && !irqEvent[2]) |=> !irqStatus_r[2];
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("interrupt status not cleared by write one");

  property p_ack_follows;
    (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("request not acknowledged after one wait state");

  property p_start_single;
    convReq.start |=> !convReq.start;
  endproperty
  a_start_single: assert property (p_start_single)
    else $error("conversion start held longer than one cycle");

endmodule // apt_pair_trigger

// File: verif/apt_far_model.sv
// Far-side model: PWM generators and timers as trigger pulsers, plus the converter.
// Assumes the bench asks for a pulse by raising fire for one cycle with fireVec.
`timescale 1ns/1ps
module apt_far_model
  import apt_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rstn,
  input  wire logic      fire,
  input  apt_trig_t      fireVec,
  input  wire logic [7:0] convLat,
  input  apt_conv_req_t  convReq,
  output apt_trig_t      trig,
  output logic           convDone
);
  logic [7:0] latCnt_r;

  // Every trigger is a one-cycle pulse, never a held level
  always_ff @(posedge ref_clk) begin
    if (!rstn) trig <= '0;
    else trig <= fire ? fireVec : '0;
  end

  // Converter answers each start once, convLat cycles later; slow or prompt
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      latCnt_r <= 8'h00;
      convDone <= 1'b0;
    end else begin
      convDone <= (latCnt_r == 8'h01);
      if (convReq.start) latCnt_r <= convLat;
      else if (latCnt_r != 8'h00) latCnt_r <= latCnt_r - 8'h01;
    end
  end
endmodule // apt_far_model

// File: verif/tb_apt_pair_trigger.sv
// Self-checking bench of the pair trigger block over classic Wishbone.
// Assumes the far model supplies triggers and converter done pulses.
`timescale 1ns/1ps
module tb_apt_pair_trigger;
  import apt_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = 8'h00;
  logic [SEL_W-1:0] sel_i = 4'h0;
  logic [DAT_W-1:0] dat_i = 32'h0, dat_o;
  logic ack_o, convDone, irq, fire = 1'b0;
  logic [7:0] convLat = 8'h0C;
  apt_trig_t trig, fireVec = '0;
  apt_conv_req_t convReq;
  int error_cnt = 0, n_checks = 0, cycles = 0;

  apt_pair_trigger dut (.ref_clk(ref_clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trig(trig), .convReq(convReq), .convDone(convDone), .irq(irq));
  apt_far_model far (.ref_clk(ref_clk), .rstn(rstn), .fire(fire), .fireVec(fireVec),
    .convLat(convLat), .convReq(convReq), .trig(trig), .convDone(convDone));

  always #50 ref_clk = ~ref_clk;

  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs about 1100 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wbXfer(input logic w, input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s,
                        input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge ref_clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wbWr(input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s,
                      input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] q;
    wbXfer(1'b1, a, s, d, q);
  endtask

  task automatic rdChk(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
    logic [DAT_W-1:0] q;
    wbXfer(1'b0, a, 4'hF, 32'h0, q);
    check(q, exp);
  endtask

  task automatic pulse(input apt_trig_t v);
    @(posedge ref_clk);
    fire    <= 1'b1;
    fireVec <= v;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask

  task automatic expStart(input logic [1:0] p);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (convReq.start !== 1'b1 && k < 40);
    check({31'h0, convReq.start}, 32'h1);
    check({30'h0, convReq.pair}, {30'h0, p});
  endtask

  task automatic waitDone();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (convDone !== 1'b1 && k < 40);
    check({31'h0, convDone}, 32'h1);
  endtask

  task automatic noStart(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      check({31'h0, convReq.start}, 32'h0);
    end
  endtask

  // Expected trigger line of each source code, built field by field
  function automatic apt_trig_t srcVec(input logic [SRC_W-1:0] c);
    apt_trig_t v;
    v = '0;
    if (c == SRC_PWM_SPECIAL) v.pwmSpecial = 1'b1;
    else if (c >= SRC_PRI_FIRST && c <= SRC_PRI_LAST) v.pwmPrimary[c - SRC_PRI_FIRST] = 1'b1;
    else if (c == SRC_TMR1) v.tmr1Match = 1'b1;
    else if (c >= SRC_SEC_FIRST && c <= SRC_SEC_LAST) v.pwmSecondary[c - SRC_SEC_FIRST] = 1'b1;
    else if (c >= SRC_CL_FIRST && c <= SRC_CL_LAST) v.pwmCurLimit[c - SRC_CL_FIRST] = 1'b1;
    else if (c == SRC_TMR2) v.tmr2Match = 1'b1;
    return v;
  endfunction

  task automatic tReset();
    rdChk(OFS_PAIR_CTRL_10_11, 32'h0);
    rdChk(OFS_PAIR_CTRL_12, 32'h0);
    rdChk(OFS_IRQ_STATUS, 32'h0);
    rdChk(OFS_IRQ_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic tUpper();
    wbWr(OFS_PAIR_CTRL_12, 4'hF, 32'hFFFF_FF40);
    rdChk(OFS_PAIR_CTRL_12, 32'h0);
    wbWr(8'h20, 4'hF, 32'hFFFF_FFFF);
    rdChk(8'h20, 32'h0);
  endtask

  // Each hardware code: only its own line starts pair 12
  task automatic tCodes();
    for (int c = 3; c < 32; c++) begin
      if (c == 13) continue;
      wbWr(OFS_PAIR_CTRL_12, 4'h1, c);
      pulse(apt_trig_t'(~srcVec(c[4:0])));
      noStart(4);
      pulse(srcVec(c[4:0]));
      expStart(2'h2);
      rdChk(OFS_PAIR_CTRL_12, 32'h40 | c);
      waitDone();
      rdChk(OFS_PAIR_CTRL_12, c);
    end
  endtask

  logic [4:0] dummy [2] = '{SRC_NONE, SRC_RESERVED};
  task automatic tSilent();
    foreach (dummy[i]) begin
      wbWr(OFS_PAIR_CTRL_12, 4'h1, {27'h0, dummy[i]});
      pulse('1);
      noStart(4);
      rdChk(OFS_PAIR_CTRL_12, {27'h0, dummy[i]});
    end
  endtask

  // One trigger hits all three pairs; they are served in order, none lost
  task automatic tQueue();
    wbWr(OFS_PAIR_CTRL_10_11, 4'h3, 32'h0C0C);
    wbWr(OFS_PAIR_CTRL_12, 4'h1, 32'h0C);
    pulse(srcVec(SRC_TMR1));
    expStart(2'h0);
    rdChk(OFS_PAIR_CTRL_10_11, 32'h4C4C);
    waitDone();
    expStart(2'h1);
    waitDone();
    expStart(2'h2);
    waitDone();
    rdChk(OFS_PAIR_CTRL_12, 32'h0C);
  endtask

  task automatic tSoft();
    wbWr(OFS_PAIR_CTRL_10_11, 4'h1, 32'h01);
    wbWr(OFS_PAIR_CTRL_10_11, 4'h1, 32'h21);
    expStart(2'h0);
    rdChk(OFS_PAIR_CTRL_10_11, 32'h0C41);
    waitDone();
    convLat <= 8'h02;
    wbWr(OFS_PAIR_CTRL_10_11, 4'h2, 32'h0200);
    wbWr(OFS_GLOBAL_CTRL, 4'h1, 32'h1);
    expStart(2'h1);
    waitDone();
    convLat <= 8'h0C;
  endtask

  task automatic tIrq();
    wbWr(OFS_IRQ_MASK, 4'h1, 32'h4);
    wbWr(OFS_PAIR_CTRL_10_11, 4'h3, 32'h000C);
    wbWr(OFS_PAIR_CTRL_12, 4'h1, 32'h8C);
    pulse(srcVec(SRC_TMR1));
    expStart(2'h0);
    waitDone();
    expStart(2'h2);
    waitDone();
    @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    rdChk(OFS_IRQ_STATUS, 32'h4);
    wbWr(OFS_IRQ_MASK, 4'h1, 32'h0);
    @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    wbWr(OFS_IRQ_MASK, 4'h1, 32'h4);
    wbWr(OFS_IRQ_STATUS, 4'h1, 32'h4);
    rdChk(OFS_IRQ_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    tReset();
    tUpper();
    tCodes();
    tSilent();
    tQueue();
    tSoft();
    tIrq();
    results();
  end
endmodule // tb_apt_pair_trigger
